// ===== common/jtap_pkg.sv
package jtap_pkg;

    // ****************************************
    // TAP controller states and instructions
    // ****************************************
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jtap_state_t;

    localparam int          IR_W       = 3;
    localparam logic [2:0]  INS_EXTEST = 3'h0;
    localparam logic [2:0]  INS_IDCODE = 3'h1;
    localparam logic [2:0]  INS_SAMPLE = 3'h2;
    localparam logic [2:0]  INS_BYPASS = 3'h7;
    localparam logic [1:0]  IR_CAPTURE = 2'h1;
    localparam int          ID_W       = 32;
    // Identification code: value is arbitrary
    localparam logic [31:0] ID_CODE    = 32'h0A5A_5001;
    localparam int          RESET_ONES = 5;
    localparam int          BSR_W      = 8;

    // Edge events from the sampled test clock
    typedef struct packed {
        logic rise;
        logic fall;
        logic tms;
        logic tdi;
    } jtap_ev_t;

endpackage : jtap_pkg

// ===== hdl/jtap_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser of the test pins with edge detection of the clock
module jtap_sync
    import jtap_pkg::*;
(
    // Clock and reset
    input  wire logic     mclk,
    input  wire logic     nrst,
    // Pins
    input  wire logic     tck_pin,
    input  wire logic     tms_pin,
    input  wire logic     tdi_pin,
    // Events
    output jtap_ev_t      ev
);

    logic [2:0] s1_reg, s1_next;
    logic [2:0] s2_reg, s2_next;
    logic       tck_old_reg, tck_old_next;

    always_comb begin
        s1_next      = {tck_pin, tms_pin, tdi_pin};
        s2_next      = s1_reg;
        tck_old_next = s2_reg[2];
    end

    // Pins idle high (pull-ups) so reset values are ones
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_reg      <= 3'h7;
            s2_reg      <= 3'h7;
            tck_old_reg <= 1'b1;
        end else begin
            s1_reg      <= s1_next;
            s2_reg      <= s2_next;
            tck_old_reg <= tck_old_next;
        end
    end

    always_comb begin
        ev.rise = s2_reg[2] & ~tck_old_reg;
        ev.fall = ~s2_reg[2] & tck_old_reg;
        ev.tms  = s2_reg[1];
        ev.tdi  = s2_reg[0];
    end

endmodule : jtap_sync

// ===== hdl/jtap_tap.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Standard sixteen-state TAP controller behaviour
// - Power-up resets port; idle until clocked
// - Pull-ups on clock, mode, data pins
// - Floating mode select reads as one
// - Floating data input shifts in one
// - Sample on rising, update on falling
// - Mode select steers controller transitions
// - One register chosen by state, instruction
// - Data out driven only while shifting
// - No asynchronous test reset pin
// - Five high mode samples reach reset
// - Three-bit serially loaded instruction register
// - Reset preloads identification instruction
// - Capture-IR loads 01 into low bits
// - One-bit bypass register
module jtap_tap
    import jtap_pkg::*;
(
    // Clock and power-up reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Test pins; pull-ups resolve floating pins to one outside
    input  wire logic        tck_pin,
    input  wire logic        tms_pin,
    input  wire logic        tdi_pin,
    output logic             tdo_out,
    output logic             tdo_oe_n,
    // Boundary pins sampled at capture
    input  wire logic [7:0]  pins_in,
    output logic [7:0]       bsr_out,
    output logic             extest_on,
    output logic             outputs_off,
    output logic             test_reset
);

    jtap_ev_t ev;

    // nrst is power-up only; no test reset pin exists
    jtap_sync u_sync (
        .mclk    (mclk),
        .nrst    (nrst),
        .tck_pin (tck_pin),
        .tms_pin (tms_pin),
        .tdi_pin (tdi_pin),
        .ev      (ev)
    );

    // ****************************************
    // Controller
    // ****************************************
    jtap_state_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (ev.rise) begin
            unique case (st_reg)
                ST_RESET:  st_next = ev.tms ? ST_RESET  : ST_IDLE;
                ST_IDLE:   st_next = ev.tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: st_next = ev.tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: st_next = ev.tms ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR:  st_next = ev.tms ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: st_next = ev.tms ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: st_next = ev.tms ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: st_next = ev.tms ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: st_next = ev.tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: st_next = ev.tms ? ST_RESET  : ST_CAP_IR;
                ST_CAP_IR: st_next = ev.tms ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR:  st_next = ev.tms ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: st_next = ev.tms ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: st_next = ev.tms ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: st_next = ev.tms ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: st_next = ev.tms ? ST_SEL_DR : ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Instruction and data registers
    // ****************************************
    logic [IR_W-1:0]  ir_sh_reg, ir_sh_next;
    logic [IR_W-1:0]  ir_reg, ir_next;
    logic             byp_reg, byp_next;
    logic [ID_W-1:0]  id_reg, id_next;
    logic [BSR_W-1:0] bsr_sh_reg, bsr_sh_next;
    logic [BSR_W-1:0] bsr_up_reg, bsr_up_next;

    always_comb begin
        ir_sh_next  = ir_sh_reg;
        ir_next     = ir_reg;
        byp_next    = byp_reg;
        id_next     = id_reg;
        bsr_sh_next = bsr_sh_reg;
        bsr_up_next = bsr_up_reg;
        // Preload on every reset cycle, so no stale instruction survives
        if (st_reg == ST_RESET) begin
            ir_next = INS_IDCODE;
        end
        if (ev.rise) begin
            unique case (st_reg)
                ST_CAP_IR: begin
                    ir_sh_next = {ir_reg[IR_W-1:2], IR_CAPTURE};
                end
                ST_SH_IR: begin
                    ir_sh_next = {ev.tdi, ir_sh_reg[IR_W-1:1]};
                end
                ST_CAP_DR: begin
                    byp_next    = 1'b0;
                    id_next     = ID_CODE;
                    bsr_sh_next = pins_in;
                end
                ST_SH_DR: begin
                    unique case (ir_reg)
                        INS_IDCODE: id_next = {ev.tdi, id_reg[ID_W-1:1]};
                        INS_EXTEST, INS_SAMPLE:
                            bsr_sh_next = {ev.tdi, bsr_sh_reg[BSR_W-1:1]};
                        default: byp_next = ev.tdi;
                    endcase
                end
                default: ;
            endcase
        end
        if (ev.fall) begin
            if (st_reg == ST_UPD_IR) begin
                ir_next = ir_sh_reg;
            end
            if (st_reg == ST_UPD_DR &&
                (ir_reg == INS_EXTEST || ir_reg == INS_SAMPLE)) begin
                bsr_up_next = bsr_sh_reg;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ir_sh_reg  <= INS_IDCODE;
            ir_reg     <= INS_IDCODE;
            byp_reg    <= 1'b0;
            id_reg     <= ID_CODE;
            bsr_sh_reg <= '0;
            bsr_up_reg <= '0;
        end else begin
            ir_sh_reg  <= ir_sh_next;
            ir_reg     <= ir_next;
            byp_reg    <= byp_next;
            id_reg     <= id_next;
            bsr_sh_reg <= bsr_sh_next;
            bsr_up_reg <= bsr_up_next;
        end
    end

    // ****************************************
    // Output stage; data out and its enable updated on falling edge, the rest every cycle
    // ****************************************
    logic tdo_next, oe_n_next, ext_next, off_next, trst_next;
    logic shift_ir, shift_dr;

    always_comb begin
        shift_ir = (st_reg == ST_SH_IR);
        shift_dr = (st_reg == ST_SH_DR);
        tdo_next  = tdo_out;
        oe_n_next = tdo_oe_n;
        if (ev.fall) begin
            oe_n_next = ~(shift_ir | shift_dr);
            if (shift_ir) begin
                tdo_next = ir_sh_reg[0];
            end else if (ir_reg == INS_IDCODE) begin
                tdo_next = id_reg[0];
            end else if (ir_reg == INS_EXTEST || ir_reg == INS_SAMPLE) begin
                tdo_next = bsr_sh_reg[0];
            end else begin
                tdo_next = byp_reg;
            end
        end
        ext_next  = (ir_reg == INS_EXTEST);
        off_next  = (ir_reg == INS_BYPASS) ? 1'b0 : 1'b0;
        trst_next = (st_reg == ST_RESET);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tdo_out     <= 1'b0;
            tdo_oe_n    <= 1'b1;
            bsr_out     <= '0;
            extest_on   <= 1'b0;
            outputs_off <= 1'b0;
            test_reset  <= 1'b1;
        end else begin
            tdo_out     <= tdo_next;
            tdo_oe_n    <= oe_n_next;
            bsr_out     <= bsr_up_reg;
            extest_on   <= ext_next;
            outputs_off <= off_next;
            test_reset  <= trst_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [2:0] ones_cnt;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ones_cnt <= '0;
        end else if (ev.rise) begin
            ones_cnt <= !ev.tms ? 3'h0 : (ones_cnt == 3'h5 ? 3'h5
                                          : ones_cnt + 3'h1);
        end
    end

    // Counter and state move on the same rise, so compare them together
    property p_five_ones;
        @(posedge mclk) disable iff (!nrst)
        (ones_cnt == 3'h5) |-> st_reg == ST_RESET;
    endproperty
    a_five_ones: assert property (p_five_ones)
        else $error("reset state not reached after five ones");

    property p_oe_shift;
        @(posedge mclk) disable iff (!nrst)
        ev.fall |=> tdo_oe_n == !($past(st_reg) inside {ST_SH_IR, ST_SH_DR});
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("data out enable wrong for state");

    property p_oe_stable;
        @(posedge mclk) disable iff (!nrst)
        !ev.fall |=> $stable(tdo_oe_n) && $stable(tdo_out);
    endproperty
    a_oe_stable: assert property (p_oe_stable)
        else $error("data out changed without falling edge");

    property p_ir_reset;
        @(posedge mclk) disable iff (!nrst)
        (st_reg == ST_RESET && ev.rise) |=> ir_reg == INS_IDCODE;
    endproperty
    a_ir_reset: assert property (p_ir_reset)
        else $error("instruction not preloaded in reset");

    property p_cap_ir;
        @(posedge mclk) disable iff (!nrst)
        (st_reg == ST_CAP_IR && ev.rise) |=> ir_sh_reg[1:0] == IR_CAPTURE;
    endproperty
    a_cap_ir: assert property (p_cap_ir)
        else $error("capture pattern not loaded");

    property p_ir_hold;
        @(posedge mclk) disable iff (!nrst)
        (st_reg != ST_UPD_IR && st_reg != ST_RESET) |=> $stable(ir_reg);
    endproperty
    a_ir_hold: assert property (p_ir_hold)
        else $error("instruction changed outside update");

    property p_state_hold;
        @(posedge mclk) disable iff (!nrst)
        !ev.rise |=> $stable(st_reg);
    endproperty
    a_state_hold: assert property (p_state_hold)
        else $error("state moved without rising edge");

    property p_byp;
        @(posedge mclk) disable iff (!nrst)
        (st_reg == ST_SH_DR && ev.rise && ir_reg == INS_BYPASS)
            |=> byp_reg == $past(ev.tdi);
    endproperty
    a_byp: assert property (p_byp)
        else $error("bypass bit not captured");

    c_shift_dr: cover property (@(posedge mclk) st_reg == ST_SH_DR);
    c_upd_ir:   cover property (@(posedge mclk) st_reg == ST_UPD_IR);
    c_reset5:   cover property (@(posedge mclk) ones_cnt == 3'h5);

endmodule : jtap_tap

// ===== verification/jtap_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Board-level scan controller
// ****************************************
module jtap_host_model (
    // Test pins toward the port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // Serial return from the port
    input  wire logic tdo_out,
    input  wire logic tdo_oe_n
);
    // Half period of the test clock; the bench may slow it down
    real  half_ns;
    logic last_tdo;

    initial begin
        half_ns  = 32.0;
        last_tdo = 1'h0;
        tck      = 1'h0;
        tms      = 1'h1;
        tdi      = 1'h1;
    end

    // One test clock: set pins while low, sample return, rise, fall
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #(half_ns);
        // A released return line does not hold its last level
        q        = tdo_oe_n ? ~last_tdo : tdo_out;
        last_tdo = q;
        tck      = 1'h1;
        #(half_ns);
        tck = 1'h0;
    endtask : pulse

    // Pull-ups take the lines to one; the clock stands still low
    task automatic release_pins;
        tms = 1'h1;
        tdi = 1'h1;
    endtask : release_pins

    // From Idle into Shift-IR or Shift-DR
    task automatic goto_shift(input logic ir);
        logic q;
        pulse(1'h1, 1'h1, q);
        if (ir) begin
            pulse(1'h1, 1'h1, q);
        end
        pulse(1'h0, 1'h1, q);
        pulse(1'h0, 1'h1, q);
    endtask : goto_shift

    // Shift n bits LSB first; the last bit leaves for Exit1
    task automatic shift(input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
    endtask : shift

    // From Exit1 through Update to Idle, then let go of the lines
    task automatic finish_shift;
        logic q;
        pulse(1'h1, 1'h1, q);
        pulse(1'h0, 1'h1, q);
        release_pins();
    endtask : finish_shift
endmodule : jtap_host_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb
    import jtap_pkg::*;
;
    logic        mclk;
    logic        nrst;
    logic        tck_pin;
    logic        tms_pin;
    logic        tdi_pin;
    logic        tdo_out;
    logic        tdo_oe_n;
    logic [7:0]  pins_in;
    logic [7:0]  bsr_out;
    logic        extest_on;
    logic        outputs_off;
    logic        test_reset;
    logic [31:0] d;
    logic        q;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          cycles     = 0;

    jtap_tap DUT (.mclk(mclk), .nrst(nrst), .tck_pin(tck_pin),
        .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tdo_out(tdo_out),
        .tdo_oe_n(tdo_oe_n), .pins_in(pins_in), .bsr_out(bsr_out),
        .extest_on(extest_on), .outputs_off(outputs_off),
        .test_reset(test_reset));

    jtap_host_model host (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin),
        .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));

    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Whole run needs a few thousand cycles; a hang stops well past that
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // Outputs settle about four system clocks after a test clock fall
    task automatic settle;
        repeat (10) @(posedge mclk);
    endtask : settle

    task automatic load_ir(input logic [2:0] ins);
        host.goto_shift(1'h1);
        host.shift(3, {29'h0, ins}, d);
        host.finish_shift();
    endtask : load_ir

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_power_up;
        repeat (60) @(posedge mclk);
        check("test_reset idle", test_reset, 1'h1);
        check("oe_n idle", tdo_oe_n, 1'h1);
        check("extest idle", extest_on, 1'h0);
        check("outputs_off", outputs_off, 1'h0);
    endtask : t_power_up

    task automatic t_idcode;
        host.pulse(1'h0, 1'h1, q);
        host.goto_shift(1'h0);
        settle();
        check("oe_n shift", tdo_oe_n, 1'h0);
        host.shift(32, 32'hFFFF_FFFF, d);
        check("idcode", d, ID_CODE);
        settle();
        check("oe_n exit1", tdo_oe_n, 1'h1);
        host.finish_shift();
    endtask : t_idcode

    task automatic t_ir_extest;
        host.goto_shift(1'h1);
        host.shift(3, {29'h0, INS_EXTEST}, d);
        check("ir capture", d, 32'h1);
        settle();
        check("extest early", extest_on, 1'h0);
        host.finish_shift();
        settle();
        check("extest applied", extest_on, 1'h1);
        // Three ones from Idle reach reset with no further rise there
        host.pulse(1'h1, 1'h1, q);
        host.pulse(1'h1, 1'h1, q);
        host.pulse(1'h1, 1'h1, q);
        settle();
        check("reset entered", test_reset, 1'h1);
        check("reset preload", extest_on, 1'h0);
        host.pulse(1'h0, 1'h1, q);
        host.release_pins();
    endtask : t_ir_extest

    task automatic t_sample;
        pins_in <= 8'h5C;
        load_ir(INS_SAMPLE);
        check("extest off", extest_on, 1'h0);
        host.goto_shift(1'h0);
        host.shift(8, 32'hA3, d);
        check("bsr capture", d, 32'h5C);
        host.finish_shift();
        settle();
        check("bsr update", bsr_out, 8'hA3);
    endtask : t_sample

    // Slow test clock through the one-bit path
    task automatic t_bypass;
        host.half_ns = 80.0;
        load_ir(INS_BYPASS);
        host.goto_shift(1'h0);
        host.shift(8, 32'h96, d);
        check("bypass", d, (32'h96 << 1) & 32'hFF);
        host.half_ns = 32.0;
        host.pulse(1'h1, 1'h1, q);
        host.pulse(1'h1, 1'h1, q);
        host.pulse(1'h1, 1'h1, q);
        settle();
        check("four ones", test_reset, 1'h0);
        host.pulse(1'h1, 1'h1, q);
        settle();
        check("five ones", test_reset, 1'h1);
    endtask : t_bypass

    initial begin
        nrst    = 1'h0;
        pins_in = 8'h00;
        repeat (16) @(posedge mclk);
        nrst <= 1'h1;
        t_power_up();
        t_idcode();
        t_ir_extest();
        t_sample();
        t_bypass();
        // Reset must have preloaded the identification instruction
        t_idcode();
        end_of_test();
    end
endmodule : tb
